// file: src/color_thresh_regs.vh
// register offsets, field positions, reset values and timing constants
`ifndef COLOR_THRESH_REGS_VH
`define COLOR_THRESH_REGS_VH

// ==================================================
// register offsets (byte addresses)
`define OFS_IRQ_CHANNEL_SELECT 8'h03
`define OFS_PART_IDENTIFICATION 8'h04
`define OFS_GAIN_AND_DIVIDER 8'h07
`define OFS_LOW_LIMIT_BYTE0 8'h08
`define OFS_LOW_LIMIT_BYTE1 8'h09
`define OFS_HIGH_LIMIT_BYTE0 8'h0a
`define OFS_HIGH_LIMIT_BYTE1 8'h0b

// ==================================================
// field positions
`define CHSEL_MSB 1
`define CHSEL_LSB 0
`define PART_ID_MSB 7
`define PART_ID_LSB 4
`define SIL_REV_MSB 3
`define SIL_REV_LSB 0
`define GAIN_MSB 5
`define GAIN_LSB 4
`define DIV_MSB 2
`define DIV_LSB 0

// ==================================================
// channel select codes
`define CH_GREEN 2'h0
`define CH_RED 2'h1
`define CH_BLUE 2'h2
`define CH_CLEAR 2'h3

// ==================================================
// persistence codes
`define PERS_EVERY 3'h0
`define PERS_SINGLE 3'h1
`define PERS_SHORT 3'h2
`define PERS_LONG 3'h3

// ==================================================
// reset values
`define RST_CHSEL 2'h0
`define RST_GAIN 2'h0
`define RST_DIV 3'h0
`define RST_LIMIT_BYTE 8'h00

// ==================================================
// divider and result limits
`define DIV_MAX_SHIFT 3'h6
`define RESULT_FULL_SCALE 16'hffff

// ==================================================
// timing
`define CLK_FREQ_HZ 100000000
`define PERS_SHORT_MS 100
`define PERS_LONG_MS 1000
`define CYCLES_PER_MS (`CLK_FREQ_HZ / 1000)

`endif

// file: src/count_scaler.v
// per-channel count divider with saturation to a 16-bit result
`include "color_thresh_regs.vh"

module count_scaler
#(
    parameter RAW_W = 24
)
(
    input wire [RAW_W-1:0] raw_count,
    input wire [2:0] div_code,
    output reg [15:0] scaled_count
);

    // ==================================================
    // shift and clamp
    reg [2:0] shift_amt;
    reg [RAW_W-1:0] shifted;

    // the 6-bit prescaler: at most six places of shift
    always @*
    begin
        shift_amt = div_code;
        shifted = {RAW_W{1'b0}};
        scaled_count = 16'h0000;
        // unused code 111 clamps to divide by 64
        if (div_code > `DIV_MAX_SHIFT)
        begin
            shift_amt = `DIV_MAX_SHIFT;
        end
        shifted = raw_count >> shift_amt;
        if (|(shifted >> 16))
        begin
            scaled_count = `RESULT_FULL_SCALE;
        end
        else
        begin
            scaled_count = shifted[15:0];
        end
    end

endmodule // count_scaler

// file: src/color_thresh_irq.v
// channel select, identification, gain/divider and threshold interrupt logic
//
// Operation
// - bits 1:0 of channel select pick green, red, blue or clear for comparison.
// - identification register is constant: part identifier high nibble, revision low.
// - gain bits 5:4 set shared analog gain 1x, 4x, 16x or 64x.
// - divider bits 2:0 shift counts right by code; code 111 unused.
// - count divider is a six-bit digital prescaling stage per channel.
// - each result is a 16-bit count that saturates at full scale.
// - low and high thresholds are built from byte pairs at 08h..0Bh.
// - interrupt when selected result is at or below low threshold.
// - interrupt when selected result is strictly above high threshold.
// - all four threshold bytes reset to 00h.
// - persistence code gates interrupts: every, single, 0.1 s, 1 s.
`include "color_thresh_regs.vh"

module color_thresh_irq
#(
    parameter RAW_W = 24,
    // identification nibbles; values are arbitrary
    parameter [3:0] PART_IDENTIFIER = 4'ha,
    parameter [3:0] SILICON_REVISION = 4'h3,
    parameter [31:0] PERS_SHORT_CYCLES = `PERS_SHORT_MS * `CYCLES_PER_MS,
    parameter [31:0] PERS_LONG_CYCLES = `PERS_LONG_MS * `CYCLES_PER_MS
)
(
    input wire clk,
    input wire rst_n,
    // byte register port
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata_ff,
    output reg reg_rd_valid_ff,
    // raw integrator counts and end-of-conversion strobe
    input wire [RAW_W-1:0] raw_green,
    input wire [RAW_W-1:0] raw_red,
    input wire [RAW_W-1:0] raw_blue,
    input wire [RAW_W-1:0] raw_clear,
    input wire conv_done,
    // controls held elsewhere in the device
    input wire [2:0] interrupt_persistence,
    input wire irq_clear,
    // outputs
    output reg [1:0] analog_gain_ff,
    output reg [2:0] count_divider_ff,
    output reg [15:0] selected_result_ff,
    output reg irq_ff
);

    // ==================================================
    // configuration storage
    reg [1:0] chan_sel_ff;
    reg [7:0] low_limit_byte0_ff;
    reg [7:0] low_limit_byte1_ff;
    reg [7:0] high_limit_byte0_ff;
    reg [7:0] high_limit_byte1_ff;

    // decode helper, used by both write and read paths
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // register writes; reserved bits are simply not stored
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chan_sel_ff <= `RST_CHSEL;
            analog_gain_ff <= `RST_GAIN;
            count_divider_ff <= `RST_DIV;
            low_limit_byte0_ff <= `RST_LIMIT_BYTE;
            low_limit_byte1_ff <= `RST_LIMIT_BYTE;
            high_limit_byte0_ff <= `RST_LIMIT_BYTE;
            high_limit_byte1_ff <= `RST_LIMIT_BYTE;
        end
        else if (reg_wr_en)
        begin
            if (hit(reg_addr, `OFS_IRQ_CHANNEL_SELECT))
            begin
                chan_sel_ff <= reg_wdata[`CHSEL_MSB:`CHSEL_LSB];
            end
            else if (hit(reg_addr, `OFS_GAIN_AND_DIVIDER))
            begin
                analog_gain_ff <= reg_wdata[`GAIN_MSB:`GAIN_LSB];
                count_divider_ff <= reg_wdata[`DIV_MSB:`DIV_LSB];
            end
            else if (hit(reg_addr, `OFS_LOW_LIMIT_BYTE0))
            begin
                low_limit_byte0_ff <= reg_wdata;
            end
            else if (hit(reg_addr, `OFS_LOW_LIMIT_BYTE1))
            begin
                low_limit_byte1_ff <= reg_wdata;
            end
            else if (hit(reg_addr, `OFS_HIGH_LIMIT_BYTE0))
            begin
                high_limit_byte0_ff <= reg_wdata;
            end
            else if (hit(reg_addr, `OFS_HIGH_LIMIT_BYTE1))
            begin
                high_limit_byte1_ff <= reg_wdata;
            end
        end
    end

    // ==================================================
    // register reads
    reg [7:0] nxt_rdata;

    // unmapped offsets and reserved bits read as zero
    always @*
    begin
        nxt_rdata = 8'h00;
        if (hit(reg_addr, `OFS_IRQ_CHANNEL_SELECT))
        begin
            nxt_rdata[`CHSEL_MSB:`CHSEL_LSB] = chan_sel_ff;
        end
        else if (hit(reg_addr, `OFS_PART_IDENTIFICATION))
        begin
            nxt_rdata[`PART_ID_MSB:`PART_ID_LSB] = PART_IDENTIFIER;
            nxt_rdata[`SIL_REV_MSB:`SIL_REV_LSB] = SILICON_REVISION;
        end
        else if (hit(reg_addr, `OFS_GAIN_AND_DIVIDER))
        begin
            nxt_rdata[`GAIN_MSB:`GAIN_LSB] = analog_gain_ff;
            nxt_rdata[`DIV_MSB:`DIV_LSB] = count_divider_ff;
        end
        else if (hit(reg_addr, `OFS_LOW_LIMIT_BYTE0))
        begin
            nxt_rdata = low_limit_byte0_ff;
        end
        else if (hit(reg_addr, `OFS_LOW_LIMIT_BYTE1))
        begin
            nxt_rdata = low_limit_byte1_ff;
        end
        else if (hit(reg_addr, `OFS_HIGH_LIMIT_BYTE0))
        begin
            nxt_rdata = high_limit_byte0_ff;
        end
        else if (hit(reg_addr, `OFS_HIGH_LIMIT_BYTE1))
        begin
            nxt_rdata = high_limit_byte1_ff;
        end
    end

    // read data is registered so the port comes from a flop
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_ff <= 8'h00;
            reg_rd_valid_ff <= 1'b0;
        end
        else
        begin
            reg_rd_valid_ff <= reg_rd_en;
            if (reg_rd_en)
            begin
                reg_rdata_ff <= nxt_rdata;
            end
        end
    end

    // ==================================================
    // channel scaling
    wire [15:0] scaled_green;
    wire [15:0] scaled_red;
    wire [15:0] scaled_blue;
    wire [15:0] scaled_clear;

    count_scaler #(.RAW_W(RAW_W)) u_scale_green
    (
        .raw_count(raw_green),
        .div_code(count_divider_ff),
        .scaled_count(scaled_green)
    );
    count_scaler #(.RAW_W(RAW_W)) u_scale_red
    (
        .raw_count(raw_red),
        .div_code(count_divider_ff),
        .scaled_count(scaled_red)
    );
    count_scaler #(.RAW_W(RAW_W)) u_scale_blue
    (
        .raw_count(raw_blue),
        .div_code(count_divider_ff),
        .scaled_count(scaled_blue)
    );
    count_scaler #(.RAW_W(RAW_W)) u_scale_clear
    (
        .raw_count(raw_clear),
        .div_code(count_divider_ff),
        .scaled_count(scaled_clear)
    );

    // ==================================================
    // comparison
    reg [15:0] sel_count;
    wire [15:0] low_limit;
    wire [15:0] high_limit;
    wire below_low;
    wire above_high;
    wire out_of_range;

    always @*
    begin
        sel_count = scaled_green;
        case (chan_sel_ff)
            `CH_GREEN: sel_count = scaled_green;
            `CH_RED: sel_count = scaled_red;
            `CH_BLUE: sel_count = scaled_blue;
            default: sel_count = scaled_clear;
        endcase
    end

    assign low_limit = {low_limit_byte1_ff, low_limit_byte0_ff};
    assign high_limit = {high_limit_byte1_ff, high_limit_byte0_ff};
    assign below_low = (sel_count <= low_limit);
    assign above_high = (sel_count > high_limit);
    assign out_of_range = below_low | above_high;

    // ==================================================
    // persistence timer
    // counts clock cycles since the first out-of-range evaluation of a run;
    // saturates so a long-idle run cannot wrap back below the limit
    reg run_ff;
    reg [31:0] run_cycles_ff;
    reg fire;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_ff <= 1'b0;
            run_cycles_ff <= 32'h0000_0000;
        end
        else if (conv_done)
        begin
            // run ends on an in-range result; the next out-of-range result starts a new run
            if (out_of_range && !run_ff)
            begin
                run_ff <= 1'b1;
                run_cycles_ff <= 32'h0000_0000;
            end
            else if (!out_of_range)
            begin
                run_ff <= 1'b0;
                run_cycles_ff <= 32'h0000_0000;
            end
            else if (run_cycles_ff != 32'hffff_ffff)
            begin
                run_cycles_ff <= run_cycles_ff + 32'h0000_0001;
            end
        end
        else if (run_ff && run_cycles_ff != 32'hffff_ffff)
        begin
            run_cycles_ff <= run_cycles_ff + 32'h0000_0001;
        end
    end

    // persistence gate; codes above 011 act as single
    always @*
    begin
        fire = 1'b0;
        case (interrupt_persistence)
            `PERS_EVERY: fire = 1'b1;
            `PERS_SHORT: fire = out_of_range && run_ff && (run_cycles_ff >= PERS_SHORT_CYCLES);
            `PERS_LONG: fire = out_of_range && run_ff && (run_cycles_ff >= PERS_LONG_CYCLES);
            default: fire = out_of_range;
        endcase
    end

    // ==================================================
    // interrupt flag and result latch
    // set and latched only on the conversion strobe; irq_clear clears the flag in any cycle without a set
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_ff <= 1'b0;
            selected_result_ff <= 16'h0000;
        end
        else
        begin
            if (conv_done)
            begin
                selected_result_ff <= sel_count;
            end
            // set wins over a clear in the same cycle
            if (conv_done && fire)
            begin
                irq_ff <= 1'b1;
            end
            else if (irq_clear)
            begin
                irq_ff <= 1'b0;
            end
        end
    end

endmodule // color_thresh_irq

// file: verif/color_thresh_irq_sva.sv
// port-level checks for the threshold interrupt block
module color_thresh_irq_sva
#(
    parameter RAW_W = 24,
    parameter [3:0] PART_IDENTIFIER = 4'ha,
    parameter [3:0] SILICON_REVISION = 4'h3
)
(
    input wire clk,
    input wire rst_n,
    input wire reg_wr_en,
    input wire reg_rd_en,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata_ff,
    input wire [RAW_W-1:0] raw_green,
    input wire [RAW_W-1:0] raw_red,
    input wire [RAW_W-1:0] raw_blue,
    input wire [RAW_W-1:0] raw_clear,
    input wire conv_done,
    input wire [2:0] interrupt_persistence,
    input wire irq_clear,
    input wire [1:0] analog_gain_ff,
    input wire [2:0] count_divider_ff,
    input wire [15:0] selected_result_ff,
    input wire irq_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==================================================
    // register port
    property p_id_read;
        reg_rd_en && reg_addr == 8'h04 |=> reg_rdata_ff == {PART_IDENTIFIER, SILICON_REVISION};
    endproperty
    a_id_read: assert property (p_id_read) else $error("id read wrong");
    property p_sel_rsv;
        reg_rd_en && reg_addr == 8'h03 |=> reg_rdata_ff[7:2] == 6'h00;
    endproperty
    a_sel_rsv: assert property (p_sel_rsv) else $error("select spare bits set");
    property p_gain_rsv;
        reg_rd_en && reg_addr == 8'h07 |=> reg_rdata_ff[7:6] == 2'h0 && !reg_rdata_ff[3];
    endproperty
    a_gain_rsv: assert property (p_gain_rsv) else $error("gain spare bits set");
    property p_cfg_write;
        reg_wr_en && reg_addr == 8'h07 |=> analog_gain_ff == $past(reg_wdata[5:4])
            && count_divider_ff == $past(reg_wdata[2:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("gain write lost");

    // ==================================================
    // conversion and interrupt
    property p_saturate;
        conv_done && |raw_green[RAW_W-1 -: 2] && |raw_red[RAW_W-1 -: 2]
            && |raw_blue[RAW_W-1 -: 2] && |raw_clear[RAW_W-1 -: 2] |=> &selected_result_ff;
    endproperty
    a_saturate: assert property (p_saturate) else $error("no saturation");
    property p_every;
        conv_done && interrupt_persistence == 3'h0 |=> irq_ff;
    endproperty
    a_every: assert property (p_every) else $error("every-cycle irq missing");
    property p_result_hold;
        !conv_done |=> $stable(selected_result_ff);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved");
    property p_irq_hold;
        !conv_done && !irq_clear |=> $stable(irq_ff);
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq moved");
endmodule // color_thresh_irq_sva

bind color_thresh_irq color_thresh_irq_sva #(.RAW_W(RAW_W), .PART_IDENTIFIER(PART_IDENTIFIER),
    .SILICON_REVISION(SILICON_REVISION)) color_thresh_irq_sva_inst (.clk, .rst_n, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_ff, .raw_green, .raw_red, .raw_blue,
    .raw_clear, .conv_done, .interrupt_persistence, .irq_clear, .analog_gain_ff,
    .count_divider_ff, .selected_result_ff, .irq_ff);

// file: verif/conv_source.sv
// converter model: raw counts with a one-cycle end-of-conversion strobe
module conv_source
#(
    parameter RAW_W = 24
)
(
    input wire clk,
    output logic [RAW_W-1:0] raw_green,
    output logic [RAW_W-1:0] raw_red,
    output logic [RAW_W-1:0] raw_blue,
    output logic [RAW_W-1:0] raw_clear,
    output logic conv_done
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle: no strobe, counts meaningless
    initial
    begin
        conv_done = 1'b0;
        {raw_green, raw_red, raw_blue, raw_clear} = '1;
    end
    // counts only valid with the strobe, so scramble them afterwards
    task automatic convert(input logic [RAW_W-1:0] g, r, b, c);
        @(posedge clk);
        #1;
        {raw_green, raw_red, raw_blue, raw_clear} = {g, r, b, c};
        conv_done = 1'b1;
        @(posedge clk);
        #1;
        conv_done = 1'b0;
        {raw_green, raw_red, raw_blue, raw_clear} = ~{g, r, b, c};
    endtask
endmodule // conv_source

// file: verif/color_adc_gain_and_threshold_irq_test.sv
// self-checking bench for the threshold interrupt block
module color_adc_gain_and_threshold_irq_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [2:0] interrupt_persistence = 3'h1;
    logic irq_clear = 1'b0;
    wire [7:0] reg_rdata_ff;
    wire reg_rd_valid_ff;
    wire [23:0] raw_green, raw_red, raw_blue, raw_clear;
    wire conv_done;
    wire [1:0] analog_gain_ff;
    wire [2:0] count_divider_ff;
    wire [15:0] selected_result_ff;
    wire irq_ff;
    int n_errors = 0;
    int n_checks = 0;

    // ==================================================
    // clock, design and converter model
    always #5 clk = ~clk;
    // short persistence limits keep the run brief
    color_thresh_irq #(.PERS_SHORT_CYCLES(32'd20), .PERS_LONG_CYCLES(32'd50)) color_thresh_irq_inst
        (.clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata_ff,
        .reg_rd_valid_ff, .raw_green, .raw_red, .raw_blue, .raw_clear, .conv_done,
        .interrupt_persistence, .irq_clear, .analog_gain_ff, .count_divider_ff,
        .selected_result_ff, .irq_ff);
    conv_source conv_source_inst (.clk, .raw_green, .raw_red, .raw_blue, .raw_clear, .conv_done);

    // ==================================================
    // access and compare tasks
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        {reg_wr_en, reg_addr, reg_wdata} = {1'b1, a, d};
        @(posedge clk);
        #1;
        reg_wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1;
        {reg_rd_en, reg_addr} = {1'b1, a};
        @(posedge clk);
        #1;
        reg_rd_en = 1'b0;
        chk("read valid", 16'h1, {15'h0, reg_rd_valid_ff});
        chk("read data", {8'h0, exp}, {8'h0, reg_rdata_ff});
    endtask
    // other channels carry 300h so a wrong selection shows in the result
    task automatic conv(input logic [1:0] ch, input logic [23:0] v, input logic [15:0] exp,
        input logic exp_irq);
        logic [23:0] raw [4];
        raw = '{24'h300, 24'h300, 24'h300, 24'h300};
        raw[ch] = v;
        wr(8'h03, {6'h0, ch});
        @(posedge clk);
        #1;
        irq_clear = 1'b1;
        @(posedge clk);
        #1;
        irq_clear = 1'b0;
        chk("irq cleared", 16'h0, {15'h0, irq_ff});
        conv_source_inst.convert(raw[0], raw[1], raw[2], raw[3]);
        chk("result", exp, selected_result_ff);
        chk("irq", {15'h0, exp_irq}, {15'h0, irq_ff});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ==================================================
    // test sequence
    initial
    begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd(8'h03, 8'h00);
        rd(8'h04, 8'ha3);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'ha3);
        wr(8'h05, 8'h5a);
        rd(8'h05, 8'h00);
        for (int a = 8; a < 12; a++)
            rd(a[7:0], 8'h00);
        $display("test reset done");
        for (int k = 0; k < 7; k++)
        begin
            wr(8'h07, {2'h0, k[1:0], 1'b0, k[2:0]});
            rd(8'h07, {2'h0, k[1:0], 1'b0, k[2:0]});
            chk("gain", {14'h0, k[1:0]}, {14'h0, analog_gain_ff});
            chk("divider", {13'h0, k[2:0]}, {13'h0, count_divider_ff});
        end
        // each limit written as a back-to-back byte pair
        wr(8'h08, 8'h00);
        wr(8'h09, 8'h01);
        wr(8'h0a, 8'h00);
        wr(8'h0b, 8'h02);
        rd(8'h09, 8'h01);
        rd(8'h0b, 8'h02);
        $display("test registers done");
        wr(8'h07, 8'h01);
        conv(2'h0, 24'h200, 16'h100, 1'b1);
        conv(2'h1, 24'h202, 16'h101, 1'b0);
        conv(2'h2, 24'h400, 16'h200, 1'b0);
        conv(2'h3, 24'h402, 16'h201, 1'b1);
        conv(2'h0, 24'h40000, 16'hffff, 1'b1);
        wr(8'h07, 8'h06);
        conv(2'h1, 24'h4000, 16'h100, 1'b1);
        $display("test compare done");
        interrupt_persistence = 3'h0;
        conv(2'h2, 24'h6000, 16'h180, 1'b1);
        interrupt_persistence = 3'h2;
        conv(2'h3, 24'h0, 16'h0, 1'b0);
        repeat (25) @(posedge clk);
        conv_source_inst.convert(24'h0, 24'h0, 24'h0, 24'h0);
        chk("irq", 16'h1, {15'h0, irq_ff});
        $display("test persistence done");
        // long limit: the run is still going, too young at first, old enough later
        interrupt_persistence = 3'h3;
        conv(2'h3, 24'h0, 16'h0, 1'b0);
        repeat (25) @(posedge clk);
        conv_source_inst.convert(24'h0, 24'h0, 24'h0, 24'h0);
        chk("irq", 16'h1, {15'h0, irq_ff});
        // codes above 011 act as single, not every
        interrupt_persistence = 3'h4;
        conv(2'h0, 24'h6000, 16'h180, 1'b0);
        conv(2'h0, 24'h2000, 16'h80, 1'b1);
        $display("test long persistence done");
        // unused divider code clamps to divide by 64
        wr(8'h07, 8'h07);
        rd(8'h07, 8'h07);
        conv(2'h1, 24'h4000, 16'h100, 1'b1);
        // every channel far beyond full scale
        conv_source_inst.convert(24'hc00000, 24'hc00000, 24'hc00000, 24'hc00000);
        chk("saturated", 16'hffff, selected_result_ff);
        $display("test divider clamp done");
        // mid-run reset brings thresholds and config back to zero
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rd(8'h03, 8'h00);
        rd(8'h07, 8'h00);
        rd(8'h09, 8'h00);
        rd(8'h0b, 8'h00);
        $display("test second reset done");
        final_report;
    end
    // watchdog well beyond the expected few hundred cycles
    initial
    begin
        #200000;
        n_errors++;
        $display("watchdog expired");
        final_report;
    end
endmodule // color_adc_gain_and_threshold_irq_test
